// [hdl/otp_defs.svh]
// Constants for the one-time-programmable memory access block
`ifndef OTP_DEFS_SVH
`define OTP_DEFS_SVH
// ==========================================================
// Link register selectors
`define OTP_LREG_DEV_CTRL 8'h00
`define OTP_LREG_PROG_CTRL 8'h01
`define OTP_LREG_ADDR_HI 8'h02
`define OTP_LREG_ADDR_LO 8'h03
`define OTP_LREG_DATA 8'h04
`define OTP_LREG_CKS0 8'h08
`define OTP_LREG_CKS1 8'h09
`define OTP_LREG_CKS2 8'h0a
`define OTP_LREG_CKS3 8'h0b
// ==========================================================
// Command values
`define OTP_DEV_HALT 8'h04
`define OTP_DEV_RESET 8'h02
`define OTP_DEV_RUN 8'h00
`define OTP_PC_STEP1 8'h40
`define OTP_PC_STEP2 8'h58
`define OTP_PC_OFF 8'h00
// ==========================================================
// Status byte returned by an address read
`define OTP_ST_BUSY_BIT 7
`define OTP_ST_ERR_BIT 6
// ==========================================================
// Memory map
`define OTP_MEM_BYTES 16384
`define OTP_USER_LIMIT 16'h3dff
`define OTP_SEC_ADDR 16'h3fff
`define OTP_ERASED 8'hff
`define OTP_CRC16_POLY 16'h1021
`define OTP_CRC32_POLY 32'h04c11db7
`define OTP_CRC16_INIT 16'h0000
`define OTP_CRC32_INIT 32'h00000000
// ==========================================================
// Timing
`define OTP_CLK_MHZ 200
`define OTP_T_PROG_US 105
`define OTP_T_BOOT_US 20
`define OTP_BOOT_CYC (`OTP_T_BOOT_US * `OTP_CLK_MHZ)
// ==========================================================
// Programmer-side software registers
`define OTP_HREG_CMD 4'h0
`define OTP_HREG_STATUS 4'h1
`define OTP_HREG_PINS 4'h2
`endif

// [hdl/otp_pkg.sv]
// Types shared by both ends of the programming link
`default_nettype none
package otp_pkg;
  // ==========================================================
  // Link command kinds
  typedef enum logic [1:0] {
    OTP_OP_AWR = 2'h0,
    OTP_OP_ARD = 2'h1,
    OTP_OP_DWR = 2'h2,
    OTP_OP_DRD = 2'h3
  } otp_op_e;
  // Program-mode sequence
  typedef enum logic [3:0] {
    OTP_M_IDLE = 4'b0001,
    OTP_M_ARMED = 4'b0010,
    OTP_M_PROG = 4'b0100,
    OTP_M_LEAVE = 4'b1000
  } otp_mode_e;
  // Background engine
  typedef enum logic [2:0] {
    OTP_E_IDLE = 3'b001,
    OTP_E_PROG = 3'b010,
    OTP_E_CRC = 3'b100
  } otp_eng_e;
endpackage
`default_nettype wire

// [hdl/otp_link_if.sv]
// Register-level programming link between programmer and device
`default_nettype none
interface otp_link_if import otp_pkg::*; ();
  logic cmd_valid;
  otp_op_e cmd_op;
  logic [7:0] cmd_data;
  logic rsp_valid;
  logic [7:0] rsp_data;
  logic vpp;
  logic rst_pin_n;
  // Device end
  modport dev (
    input cmd_valid, cmd_op, cmd_data, vpp, rst_pin_n,
    output rsp_valid, rsp_data
  );
  // Programmer end
  modport prog (
    output cmd_valid, cmd_op, cmd_data, vpp, rst_pin_n,
    input rsp_valid, rsp_data
  );
endinterface
`default_nettype wire

// [hdl/otp_prog_end.sv]
// Programmer end: turns software register accesses into link commands
`include "otp_defs.svh"
`default_nettype none
module otp_prog_end import otp_pkg::*; (
  input wire logic i_mclk, // System clock
  input wire logic i_rst_n, // Async reset, active low
  input wire logic [3:0] i_addr, // Register address
  input wire logic [15:0] i_wdata, // Write data
  input wire logic i_wr, // Write strobe
  input wire logic i_rd, // Read strobe
  output logic [15:0] o_rdata, // Read data, cycle after strobe
  otp_link_if.prog link // Link to device
);
  localparam logic [12:0] BOOT_CYC = 13'(`OTP_BOOT_CYC);

  logic [12:0] wait_r;
  logic wait_rsp_r;
  logic rsp_new_r;
  logic [7:0] rsp_r;
  logic cmd_valid_r;
  otp_op_e cmd_op_r;
  logic [7:0] cmd_data_r;
  logic vpp_r;
  logic rst_pin_r;

  // ==========================================================
  // Decode
  wire busy = wait_rsp_r | rst_pin_r | (wait_r != 13'h0) | cmd_valid_r;
  wire cmd_wr = i_wr & (i_addr == `OTP_HREG_CMD) & ~busy;
  wire pin_wr = i_wr & (i_addr == `OTP_HREG_PINS);
  wire st_rd = i_rd & (i_addr == `OTP_HREG_STATUS);
  wire [15:0] rd_mux =
    (i_addr == `OTP_HREG_STATUS) ? {rsp_r, 6'h0, rsp_new_r, busy} :
    (i_addr == `OTP_HREG_PINS) ? {14'h0, rst_pin_r, vpp_r} : 16'h0;

  // Pins; reset release starts the quiet time before commands
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      vpp_r <= 1'b0;
      rst_pin_r <= 1'b0;
      wait_r <= BOOT_CYC;
    end else begin
      if (pin_wr) begin
        vpp_r <= i_wdata[0];
        rst_pin_r <= i_wdata[1];
      end
      if (rst_pin_r) begin
        wait_r <= BOOT_CYC;
      end else if (wait_r != 13'h0) begin
        wait_r <= wait_r - 13'h1;
      end
    end
  end

  // Command issue; commands while busy are dropped
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cmd_valid_r <= 1'b0;
      cmd_op_r <= OTP_OP_AWR;
      cmd_data_r <= 8'h00;
    end else begin
      cmd_valid_r <= cmd_wr;
      if (cmd_wr) begin
        cmd_op_r <= otp_op_e'(i_wdata[9:8]);
        cmd_data_r <= i_wdata[7:0];
      end
    end
  end

  // Answer capture; a fresh answer clears when status is read
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wait_rsp_r <= 1'b0;
      rsp_new_r <= 1'b0;
      rsp_r <= 8'h00;
    end else begin
      if (cmd_wr) begin
        wait_rsp_r <= i_wdata[8]; // Odd op codes are reads
      end else if (link.rsp_valid) begin
        wait_rsp_r <= 1'b0;
      end
      if (link.rsp_valid) begin
        rsp_r <= link.rsp_data;
        rsp_new_r <= 1'b1; // Arrival wins over the clear
      end else if (st_rd) begin
        rsp_new_r <= 1'b0;
      end
    end
  end

  // Read port
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= 16'h0;
    end else if (i_rd) begin
      o_rdata <= rd_mux;
    end
  end

  assign link.cmd_valid = cmd_valid_r;
  assign link.cmd_op = cmd_op_r;
  assign link.cmd_data = cmd_data_r;
  assign link.vpp = vpp_r;
  assign link.rst_pin_n = ~rst_pin_r;
endmodule
`default_nettype wire

// [hdl/otp_dev_end.sv]
// Device end: program mode, byte programming, locks and checksums
// Behaviour
// - Programmer waits 20 us after pin reset
// - Control value 0x04 holds core in reset
// - Program mode entered by 0x40 then 0x58
// - Programmer loads address before data
// - Data write programs byte, address increments
// - Programmer polls busy by address read
// - Failed write shows error flag on poll
// - Programmer continues sequentially or reloads address
// - Exit by 0x40, remove voltage, 0x00
// - Control 0x02 then 0x00 resets device
// - Byte programming takes 105 us, busy set
// - Each location programmable once, no erase
// - 0x3E00 to 0x3FFF not for code
// - Security byte gates access, always readable
// - Zero in bits 7-4 blocks writes
// - Zero in bits 3-0 blocks reads
// - Checksums work even when fully locked
// - Block checksum only on aligned 256 bytes
// - Checksum byte 1 write starts 32-bit CRC
// - Checksum byte 0 write starts block CRC
// - Busy set while checksum runs
// - Programmer resets before 32-bit after 16-bit
// - Access beyond user limit forces reset, except the security byte
`include "otp_defs.svh"
`default_nettype none
module otp_dev_end import otp_pkg::*; #(
  parameter int PROG_CYC = `OTP_T_PROG_US * `OTP_CLK_MHZ
) (
  input wire logic i_mclk, // System clock
  input wire logic i_rst_n, // Async reset, active low
  otp_link_if.dev link, // Programming link
  output logic o_core_hold, // Core held in reset
  output logic o_prog_mode, // Program mode active
  output logic o_busy, // Programming or checksum running
  output logic o_mem_err_rst // One-cycle memory error reset
);
  // ==========================================================
  // Checksum functions, one byte per call, MSB first
  function automatic logic [15:0] crc16_f(input logic [15:0] c,
                                          input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {d, 8'h00};
    for (int i = 0; i < 8; i++) begin
      r = r[15] ? ((r << 1) ^ `OTP_CRC16_POLY) : (r << 1);
    end
    return r;
  endfunction

  function automatic logic [31:0] crc32_f(input logic [31:0] c,
                                          input logic [7:0] d);
    logic [31:0] r;
    r = c ^ {d, 24'h0};
    for (int i = 0; i < 8; i++) begin
      r = r[31] ? ((r << 1) ^ `OTP_CRC32_POLY) : (r << 1);
    end
    return r;
  endfunction

  // Outside user space, except the security byte
  function automatic logic illegal_f(input logic [15:0] a);
    return (a > `OTP_USER_LIMIT) && (a != `OTP_SEC_ADDR);
  endfunction

  // ==========================================================
  // State
  logic [7:0] mem [`OTP_MEM_BYTES];
  logic [`OTP_MEM_BYTES-1:0] used_r;
  logic [7:0] sel_r;
  logic [7:0] dev_ctrl_r;
  logic [7:0] pc_r;
  otp_mode_e mode_r;
  otp_eng_e eng_r;
  logic [15:0] addr_r;
  logic [15:0] pa_r;
  logic [7:0] pd_r;
  logic fail_r;
  logic err_r;
  logic [15:0] cnt_r;
  logic [31:0] crc_r;
  logic wide_r;
  logic [15:0] ca_r;
  logic [15:0] ce_r;
  logic rsp_valid_r;
  logic [7:0] rsp_r;

  // ==========================================================
  // Decode
  wire cv = link.cmd_valid;
  wire [7:0] cd = link.cmd_data;
  wire awr = cv & (link.cmd_op == OTP_OP_AWR);
  wire ard = cv & (link.cmd_op == OTP_OP_ARD);
  wire dwr = cv & (link.cmd_op == OTP_OP_DWR);
  wire drd = cv & (link.cmd_op == OTP_OP_DRD);
  wire idle = (eng_r == OTP_E_IDLE);
  wire busy = ~idle;
  wire [13:0] ai = addr_r[13:0];
  wire [13:0] si = 14'(`OTP_SEC_ADDR);
  wire [13:0] ci = ca_r[13:0];
  // Unwritten cells read as erased
  wire [7:0] sec = used_r[si] ? mem[si] : `OTP_ERASED;
  wire [7:0] cur = used_r[ai] ? mem[ai] : `OTP_ERASED;
  wire [7:0] cbyte = used_r[ci] ? mem[ci] : `OTP_ERASED;
  wire wlock = ~&sec[7:4];
  wire rlock = ~&sec[3:0];
  wire d_wr = dwr & (sel_r == `OTP_LREG_DATA);
  wire d_rd = drd & (sel_r == `OTP_LREG_DATA);
  // Bad address on a data access resets the device
  wire mem_err = (d_wr | d_rd) & illegal_f(addr_r);
  // Byte write accepted only in program mode and when idle
  wire pg_go = d_wr & idle & ~mem_err & (mode_r == OTP_M_PROG);
  // Locked, reused or unpowered byte writes fail
  wire pg_fail = wlock | used_r[ai] | ~link.vpp;
  wire c16_go = dwr & idle & (sel_r == `OTP_LREG_CKS0);
  wire c32_go = dwr & idle & (sel_r == `OTP_LREG_CKS1);
  wire dev_rst = awr | ~dwr | (sel_r != `OTP_LREG_DEV_CTRL) ? 1'b0 :
                 (dev_ctrl_r == `OTP_DEV_RESET) &
                 (cd == `OTP_DEV_RUN);
  // Pin, link-commanded and memory-error resets clear session state
  wire srst = ~link.rst_pin_n | dev_rst | mem_err;
  wire [15:0] prog_cyc = 16'(PROG_CYC);
  // Reads: security byte bypasses the read lock
  wire [7:0] data_rd = (rlock && addr_r != `OTP_SEC_ADDR) ? 8'h00 :
                       cur;
  wire [7:0] rd_mux =
    (sel_r == `OTP_LREG_DEV_CTRL) ? dev_ctrl_r :
    (sel_r == `OTP_LREG_PROG_CTRL) ? pc_r :
    (sel_r == `OTP_LREG_ADDR_HI) ? addr_r[15:8] :
    (sel_r == `OTP_LREG_ADDR_LO) ? addr_r[7:0] :
    (sel_r == `OTP_LREG_DATA) ? data_rd :
    (sel_r == `OTP_LREG_CKS0) ? crc_r[7:0] :
    (sel_r == `OTP_LREG_CKS1) ? crc_r[15:8] :
    (sel_r == `OTP_LREG_CKS2) ? crc_r[23:16] :
    (sel_r == `OTP_LREG_CKS3) ? crc_r[31:24] : 8'h00;
  wire [7:0] status = {busy, err_r, 6'h0};

  // ==========================================================
  // Register select, control registers and program-mode sequence
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sel_r <= 8'h00;
      dev_ctrl_r <= 8'h00;
      pc_r <= 8'h00;
      mode_r <= OTP_M_IDLE;
    end else if (srst) begin
      sel_r <= 8'h00;
      dev_ctrl_r <= 8'h00;
      pc_r <= 8'h00;
      mode_r <= OTP_M_IDLE;
    end else begin
      if (awr) begin
        sel_r <= cd;
      end
      if (dwr && sel_r == `OTP_LREG_DEV_CTRL) begin
        dev_ctrl_r <= cd;
      end
      if (dwr && sel_r == `OTP_LREG_PROG_CTRL) begin
        pc_r <= cd;
        case (mode_r)
          OTP_M_IDLE: begin
            // Entry requires the core already held
            if (cd == `OTP_PC_STEP1 && dev_ctrl_r == `OTP_DEV_HALT) begin
              mode_r <= OTP_M_ARMED;
            end
          end
          OTP_M_ARMED: begin
            mode_r <= (cd == `OTP_PC_STEP2) ? OTP_M_PROG :
                      OTP_M_IDLE;
          end
          OTP_M_PROG: begin
            if (cd == `OTP_PC_STEP1) begin
              mode_r <= OTP_M_LEAVE;
            end
          end
          OTP_M_LEAVE: begin
            if (cd == `OTP_PC_OFF) begin
              mode_r <= OTP_M_IDLE;
            end
          end
          default: begin
            mode_r <= OTP_M_IDLE;
          end
        endcase
      end
    end
  end

  // Address: loaded by halves, stepped by each accepted byte write
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      addr_r <= 16'h0;
    end else if (srst) begin
      addr_r <= 16'h0;
    end else if (pg_go) begin
      addr_r <= addr_r + 16'h1;
    end else if (dwr && idle && sel_r == `OTP_LREG_ADDR_HI) begin
      addr_r <= {cd, addr_r[7:0]};
    end else if (dwr && idle && sel_r == `OTP_LREG_ADDR_LO) begin
      addr_r <= {addr_r[15:8], cd};
    end
  end

  // Engine: byte programming timer and checksum walk
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      eng_r <= OTP_E_IDLE;
      cnt_r <= 16'h0;
      pa_r <= 16'h0;
      pd_r <= 8'h00;
      fail_r <= 1'b0;
      err_r <= 1'b0;
      crc_r <= 32'h0;
      wide_r <= 1'b0;
      ca_r <= 16'h0;
      ce_r <= 16'h0;
    end else if (srst) begin
      eng_r <= OTP_E_IDLE;
      cnt_r <= 16'h0;
      fail_r <= 1'b0;
      err_r <= 1'b0;
    end else begin
      case (eng_r)
        OTP_E_IDLE: begin
          if (pg_go) begin
            eng_r <= OTP_E_PROG;
            cnt_r <= prog_cyc;
            pa_r <= addr_r;
            pd_r <= cd;
            fail_r <= pg_fail;
            err_r <= 1'b0;
          end else if (c16_go) begin
            eng_r <= OTP_E_CRC;
            wide_r <= 1'b0;
            ca_r <= {cd, 8'h00};
            ce_r <= {cd, 8'hff};
            crc_r <= {16'h0, `OTP_CRC16_INIT};
          end else if (c32_go) begin
            eng_r <= OTP_E_CRC;
            wide_r <= 1'b1;
            ca_r <= 16'h0;
            ce_r <= `OTP_USER_LIMIT;
            crc_r <= `OTP_CRC32_INIT;
          end
        end
        OTP_E_PROG: begin
          cnt_r <= cnt_r - 16'h1;
          if (cnt_r == 16'h1) begin
            eng_r <= OTP_E_IDLE;
            err_r <= fail_r | ~link.vpp;
          end
        end
        OTP_E_CRC: begin
          crc_r <= wide_r ? crc32_f(crc_r, cbyte) :
                   {16'h0, crc16_f(crc_r[15:0], cbyte)};
          ca_r <= ca_r + 16'h1;
          if (ca_r == ce_r) begin
            eng_r <= OTP_E_IDLE;
          end
        end
        default: begin
          eng_r <= OTP_E_IDLE;
        end
      endcase
    end
  end

  // One-time cells: a cell is written at most once, never erased
  always_ff @(posedge i_mclk) begin
    if (eng_r == OTP_E_PROG && cnt_r == 16'h1 && !fail_r && link.vpp) begin
      mem[pa_r[13:0]] <= pd_r;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      used_r <= '0;
    end else if (eng_r == OTP_E_PROG && cnt_r == 16'h1 &&
                 !fail_r && link.vpp) begin
      used_r[pa_r[13:0]] <= 1'b1;
    end
  end

  // Link answers one cycle after each read command, except a data read that raises a memory error
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rsp_valid_r <= 1'b0;
      rsp_r <= 8'h00;
    end else begin
      rsp_valid_r <= (ard | drd) & ~mem_err;
      if (ard) begin
        rsp_r <= status;
      end else if (drd) begin
        rsp_r <= rd_mux;
      end
    end
  end

  // User-side outputs
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_core_hold <= 1'b0;
      o_prog_mode <= 1'b0;
      o_busy <= 1'b0;
      o_mem_err_rst <= 1'b0;
    end else begin
      o_core_hold <= (dev_ctrl_r == `OTP_DEV_HALT);
      o_prog_mode <= (mode_r == OTP_M_PROG);
      o_busy <= busy;
      o_mem_err_rst <= mem_err;
    end
  end

  assign link.rsp_valid = rsp_valid_r;
  assign link.rsp_data = rsp_r;
endmodule
`default_nettype wire

// [tb/otp_link_checker.sv]
// Protocol checker for the device side of the programming link
`include "otp_defs.svh"
`default_nettype none
module otp_link_checker import otp_pkg::*; #(
  parameter int PROG_CYC = 40
) (
  input wire logic i_mclk, // System clock
  input wire logic i_rst_n, // Reset, active low
  input wire logic cmd_valid, // Command strobe
  input wire otp_op_e cmd_op, // Command kind
  input wire logic [7:0] cmd_data, // Command byte
  input wire logic rsp_valid, // Answer strobe
  input wire logic [7:0] rsp_data, // Answer byte
  input wire logic o_core_hold, // Core held
  input wire logic o_prog_mode, // Program mode
  input wire logic o_busy, // Engine busy
  input wire logic o_mem_err_rst // Memory error reset
);
  // ==========================================================
  // Helpers: selected register and busy length
  logic [7:0] sel_r;
  logic [15:0] busy_cnt_r;
  wire logic is_wr = cmd_valid && cmd_op == OTP_OP_DWR;
  wire logic is_ard = cmd_valid && cmd_op == OTP_OP_ARD;
  wire logic wr58 = is_wr && sel_r == `OTP_LREG_PROG_CTRL &&
    cmd_data == `OTP_PC_STEP2;
  // Selection is only tracked, soft resets leave it stale on purpose
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sel_r <= 8'h00;
      busy_cnt_r <= 16'h0000;
    end else begin
      if (cmd_valid && cmd_op == OTP_OP_AWR)
        sel_r <= cmd_data;
      busy_cnt_r <= o_busy ? busy_cnt_r + 16'h0001 : 16'h0000;
    end
  end
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  // ==========================================================
  // Properties
  sequence s_status_ans;
    rsp_valid ##0 $past(cmd_op) == OTP_OP_ARD;
  endsequence
  sequence s_start;
    is_wr && !o_busy;
  endsequence
  rsp_cause_a: assert property (rsp_valid |->
    $past(cmd_valid) && $past(cmd_op) inside {OTP_OP_ARD, OTP_OP_DRD})
    else $error("answer without a read command");
  status_ans_a: assert property (is_ard |=> rsp_valid)
    else $error("status read not answered");
  status_fmt_a: assert property (s_status_ans |->
    rsp_data[5:0] == 6'h00 && rsp_data[7] == o_busy)
    else $error("status byte wrong");
  busy_len_a: assert property ($fell(o_busy) |->
    busy_cnt_r == PROG_CYC || busy_cnt_r == 256 || busy_cnt_r == 15872)
    else $error("busy length wrong");
  mode_entry_a: assert property ($rose(o_prog_mode) |->
    o_core_hold && ($past(wr58) || $past(wr58, 2)))
    else $error("program mode without sequence");
  core_hold_a: assert property (is_wr &&
    sel_r == `OTP_LREG_DEV_CTRL && cmd_data == `OTP_DEV_HALT
    |-> ##[1:2] o_core_hold) else $error("core not held");
  crc_busy_a: assert property (s_start ##0
    sel_r inside {`OTP_LREG_CKS0, `OTP_LREG_CKS1} |-> ##[1:3] o_busy)
    else $error("checksum did not start");
  byte_busy_a: assert property (s_start ##0 o_prog_mode &&
    sel_r == `OTP_LREG_DATA |-> ##[1:3] o_busy)
    else $error("byte write did not start");
  mem_err_a: assert property (o_mem_err_rst |->
    ##[0:2] !o_prog_mode) else $error("memory error left mode on");
endmodule
`default_nettype wire

// [tb/otp_program_security_crc_test.sv]
// Testbench joining the programmer end and the device end
`include "otp_defs.svh"
`default_nettype none
module otp_program_security_crc_test import otp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PCYC = 40;
  logic i_mclk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [3:0] i_addr = 4'h0;
  logic [15:0] i_wdata = 16'h0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [15:0] o_rdata;
  logic o_core_hold, o_prog_mode, o_busy, o_mem_err_rst;
  int n_fail = 0;
  int total_checks = 0;
  logic err_seen = 1'b0;
  logic [7:0] mem [0:16383];
  logic [15:0] st;
  logic [7:0] r;
  int n;
  // Clock and memory error latch
  always #2.5 i_mclk = ~i_mclk;
  always @(posedge i_mclk)
    if (o_mem_err_rst)
      err_seen <= 1'b1;
  otp_link_if otp_link_if_inst ();
  otp_prog_end otp_prog_end_inst (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .link(otp_link_if_inst.prog));
  otp_dev_end #(.PROG_CYC(PCYC)) otp_dev_end_inst (.i_mclk(i_mclk),
    .i_rst_n(i_rst_n), .link(otp_link_if_inst.dev),
    .o_core_hold(o_core_hold), .o_prog_mode(o_prog_mode),
    .o_busy(o_busy), .o_mem_err_rst(o_mem_err_rst));
  otp_link_checker #(.PROG_CYC(PCYC)) otp_link_checker_inst (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n),
    .cmd_valid(otp_link_if_inst.cmd_valid),
    .cmd_op(otp_link_if_inst.cmd_op), .cmd_data(otp_link_if_inst.cmd_data),
    .rsp_valid(otp_link_if_inst.rsp_valid),
    .rsp_data(otp_link_if_inst.rsp_data), .o_core_hold(o_core_hold),
    .o_prog_mode(o_prog_mode), .o_busy(o_busy),
    .o_mem_err_rst(o_mem_err_rst));
  // ==========================================================
  // Software port and link command tasks
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_mclk);
    i_wr <= 1'b0;
    @(posedge i_mclk);
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    @(posedge i_mclk);
    d = o_rdata;
  endtask
  // Bounded wait, the boot wait alone takes 4000 cycles
  task automatic idle();
    int k;
    k = 0;
    rd(`OTP_HREG_STATUS, st);
    while (st[0] !== 1'b0 && k < 3000) begin
      rd(`OTP_HREG_STATUS, st);
      k++;
    end
    if (k == 3000)
      n_fail++;
  endtask
  task automatic cmd(input otp_op_e op, input logic [7:0] d);
    idle();
    wr(`OTP_HREG_CMD, {6'h00, op, d});
    idle();
    r = st[15:8];
    chk(16'(st[1]), 16'(op inside {OTP_OP_ARD, OTP_OP_DRD}));
  endtask
  task automatic put(input logic [7:0] s, input logic [7:0] v);
    cmd(OTP_OP_AWR, s);
    cmd(OTP_OP_DWR, v);
  endtask
  task automatic get(input logic [7:0] s);
    cmd(OTP_OP_AWR, s);
    cmd(OTP_OP_DRD, 8'h00);
  endtask
  // Counts status polls that still saw busy
  task automatic poll();
    n = 0;
    cmd(OTP_OP_ARD, 8'h00);
    while (r[7] !== 1'b0 && n < 20000) begin
      cmd(OTP_OP_ARD, 8'h00);
      n++;
    end
  endtask
  task automatic seek(input logic [15:0] a);
    put(`OTP_LREG_ADDR_HI, a[15:8]);
    put(`OTP_LREG_ADDR_LO, a[7:0]);
  endtask
  task automatic pbyte(input logic [15:0] a, input logic [7:0] v,
    input logic e);
    seek(a);
    put(`OTP_LREG_DATA, v);
    poll();
    chk(16'(n > 0), 16'h0001);
    chk(16'(r[6]), 16'(e));
    if (!e)
      mem[a] = v;
  endtask
  task automatic enter();
    put(`OTP_LREG_DEV_CTRL, `OTP_DEV_HALT);
    put(`OTP_LREG_PROG_CTRL, `OTP_PC_STEP1);
    cmd(OTP_OP_DWR, `OTP_PC_STEP2);
  endtask
  // ==========================================================
  // Checksum models, MSB first from a zero start
  function automatic logic [15:0] c16(input logic [15:0] c,
    input logic [7:0] b);
    c = c ^ {b, 8'h00};
    for (int i = 0; i < 8; i++)
      c = c[15] ? (c << 1) ^ `OTP_CRC16_POLY : c << 1;
    return c;
  endfunction
  function automatic logic [31:0] c32(input logic [31:0] c,
    input logic [7:0] b);
    c = c ^ {b, 24'h000000};
    for (int i = 0; i < 8; i++)
      c = c[31] ? (c << 1) ^ `OTP_CRC32_POLY : c << 1;
    return c;
  endfunction
  task automatic t_crc16(input logic [7:0] blk);
    logic [15:0] c;
    c = `OTP_CRC16_INIT;
    for (int i = 0; i < 256; i++)
      c = c16(c, mem[{blk, 8'(i)}]);
    put(`OTP_LREG_CKS0, blk);
    poll();
    chk(16'(n > 0), 16'h0001);
    get(`OTP_LREG_CKS1);
    chk({8'h00, r}, {8'h00, c[15:8]});
    get(`OTP_LREG_CKS0);
    chk({8'h00, r}, {8'h00, c[7:0]});
  endtask
  task automatic t_crc32();
    logic [31:0] c;
    c = `OTP_CRC32_INIT;
    for (int i = 0; i <= 16'h3dff; i++)
      c = c32(c, mem[i]);
    put(`OTP_LREG_CKS1, 8'h00);
    poll();
    for (int k = 0; k < 4; k++) begin
      get(`OTP_LREG_CKS0 + 8'(k));
      chk({8'h00, r}, {8'h00, c[8*k +: 8]});
    end
  endtask
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // ==========================================================
  // Main sequence; the memory error goes last since it leaves the
  // programmer end waiting for an answer that never comes
  initial begin
    foreach (mem[i])
      mem[i] = `OTP_ERASED;
    repeat (5) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    rd(`OTP_HREG_STATUS, st);
    chk(16'(st[0]), 16'h0001);
    put(`OTP_LREG_DEV_CTRL, `OTP_DEV_HALT);
    chk(16'(o_core_hold), 16'h0001);
    put(`OTP_LREG_PROG_CTRL, `OTP_PC_STEP1);
    chk(16'(o_prog_mode), 16'h0000);
    cmd(OTP_OP_DWR, `OTP_PC_STEP2);
    chk(16'(o_prog_mode), 16'h0001);
    wr(`OTP_HREG_PINS, 16'h0001);
    seek(16'h0100);
    put(`OTP_LREG_DATA, 8'h12);
    poll();
    cmd(OTP_OP_DWR, 8'h34);
    poll();
    mem[16'h0100] = 8'h12;
    mem[16'h0101] = 8'h34;
    seek(16'h0101);
    get(`OTP_LREG_DATA);
    chk({8'h00, r}, 16'h0034);
    pbyte(16'h0100, 8'h12, 1'b1);
    pbyte(16'h0102, 8'h56, 1'b0);
    t_crc32();
    t_crc16(8'h01);
    pbyte(16'h3fff, 8'h30, 1'b0);
    seek(16'h3fff);
    get(`OTP_LREG_DATA);
    chk({8'h00, r}, 16'h0030);
    seek(16'h0100);
    get(`OTP_LREG_DATA);
    chk({8'h00, r}, 16'h0000);
    pbyte(16'h0103, 8'h77, 1'b1);
    t_crc16(8'h01);
    put(`OTP_LREG_PROG_CTRL, `OTP_PC_STEP1);
    wr(`OTP_HREG_PINS, 16'h0000);
    cmd(OTP_OP_DWR, `OTP_PC_OFF);
    chk(16'(o_prog_mode), 16'h0000);
    enter();
    put(`OTP_LREG_DEV_CTRL, `OTP_DEV_RESET);
    cmd(OTP_OP_DWR, `OTP_DEV_RUN);
    chk(16'(o_prog_mode), 16'h0000);
    enter();
    chk(16'(o_prog_mode), 16'h0001);
    // Pin reset drops the session and restarts the quiet time
    wr(`OTP_HREG_PINS, 16'h0002);
    wr(`OTP_HREG_PINS, 16'h0000);
    chk(16'(o_prog_mode), 16'h0000);
    rd(`OTP_HREG_STATUS, st);
    chk(16'(st[0]), 16'h0001);
    enter();
    seek(16'h3e00);
    cmd(OTP_OP_AWR, `OTP_LREG_DATA);
    wr(`OTP_HREG_CMD, {6'h00, OTP_OP_DRD, 8'h00});
    repeat (10) @(posedge i_mclk);
    chk(16'(err_seen), 16'h0001);
    chk(16'(o_prog_mode), 16'h0000);
    end_of_test();
  end
  // Watchdog, the run needs about 25000 cycles
  initial begin
    repeat (60000) @(posedge i_mclk);
    n_fail++;
    end_of_test();
  end
endmodule
`default_nettype wire
